// ---- hw/pbo_ctrl.sv ----
// Pushbutton on/off controller with latched power output and interrupt
`timescale 1ns/1ps
module pbo_ctrl
    import pbo_pkg::*;
#(
    parameter logic [31:0] GLITCH = GLITCH_CYC,
    parameter logic [31:0] DEBOUNCE = DEBOUNCE_CYC,
    parameter logic [31:0] LONG_PRESS = LONG_PRESS_CYC,
    parameter logic [31:0] IRQ_LEN = IRQ_CYC,
    parameter logic OFF_ON_LONG = OFF_ON_LONG_DEF
)
(
    input wire logic I_SYS_CLK,
    input wire logic I_RST,
    input wire logic I_CE,
    input wire logic I_BUTTON_IN_N,
    input wire logic I_FORCE_OFF_N,
    output logic O_POWER,
    output logic O_IRQ_N_OUT,
    output logic O_IRQ_N_OE
)
;
    // Build-time variant selection through the parameters above
    localparam logic [31:0] LONG_IRQ = 32'(IRQ_LEN * LONG_IRQ_MULT);
    localparam logic [31:0] BLANK = 32'(IRQ_LEN * BLANK_MULT);

    pbo_state_t st_ff;
    pbo_state_t nxt_st;
    logic held;
    logic db_ev;
    logic lp_ev;
    logic clr_ok;

    pbo_glitch #(.GLITCH(GLITCH)) u_glitch (
        .i_clk(I_SYS_CLK),
        .i_rst(I_RST),
        .i_ce(I_CE),
        .i_button_in_n(I_BUTTON_IN_N),
        .o_held(held)
    );

    assign db_ev = held && !st_ff.db_done && (st_ff.press_cnt == DEBOUNCE - 32'h1);
    assign lp_ev = held && !st_ff.lp_done && (st_ff.press_cnt == LONG_PRESS - 32'h1);
    assign clr_ok = st_ff.power && (st_ff.blank_cnt == '0);

    always_comb
    begin
        nxt_st = st_ff;
        if (st_ff.irq_cnt != '0)
        begin
            nxt_st.irq_cnt = st_ff.irq_cnt - 32'h1;
        end
        if (st_ff.blank_cnt != '0)
        begin
            nxt_st.blank_cnt = st_ff.blank_cnt - 32'h1;
        end
        if (!held)
        begin
            nxt_st.press_cnt = '0;
            nxt_st.db_done = 1'b0;
            nxt_st.lp_done = 1'b0;
        end
        else if (st_ff.press_cnt < LONG_PRESS)
        begin
            nxt_st.press_cnt = st_ff.press_cnt + 32'h1;
        end
        if (!I_FORCE_OFF_N && clr_ok)
        begin
            nxt_st.power = 1'b0;
        end
        if (db_ev)
        begin
            nxt_st.db_done = 1'b1;
            nxt_st.power = 1'b1;
            nxt_st.irq_cnt = IRQ_LEN;
            nxt_st.blank_cnt = BLANK;
        end
        if (lp_ev)
        begin
            // Only once per closure, so holding longer adds nothing
            nxt_st.lp_done = 1'b1;
            nxt_st.irq_cnt = LONG_IRQ;
            if (OFF_ON_LONG)
            begin
                nxt_st.power = 1'b0;
            end
        end
    end

    always_ff @(posedge I_SYS_CLK or posedge I_RST)
    begin
        if (I_RST)
        begin
            st_ff <= '0;
        end
        else if (I_CE)
        begin
            st_ff <= nxt_st;
        end
    end

    assign O_POWER = st_ff.power;
    assign O_IRQ_N_OUT = 1'b0;
    assign O_IRQ_N_OE = (st_ff.irq_cnt != '0);

    property p_restart;
        @(posedge I_SYS_CLK) disable iff (I_RST)
        (I_CE && !held) |=> (st_ff.press_cnt == '0);
    endproperty
    a_restart: assert property (p_restart) else $error("Press count not restarted");

    property p_turn_on;
        @(posedge I_SYS_CLK) disable iff (I_RST)
        (I_CE && db_ev && !lp_ev) |=> (O_POWER && O_IRQ_N_OE && st_ff.irq_cnt == IRQ_LEN);
    endproperty
    a_turn_on: assert property (p_turn_on) else $error("Debounced press did not turn on");

    property p_on_cause;
        @(posedge I_SYS_CLK) disable iff (I_RST)
        $rose(O_POWER) |-> $past(db_ev) && $past(I_CE);
    endproperty
    a_on_cause: assert property (p_on_cause) else $error("Power rose without debounce");

    property p_long_off;
        @(posedge I_SYS_CLK) disable iff (I_RST)
        (I_CE && lp_ev && OFF_ON_LONG) |=> !O_POWER;
    endproperty
    a_long_off: assert property (p_long_off) else $error("Long press did not turn off");

    property p_long_stay;
        @(posedge I_SYS_CLK) disable iff (I_RST)
        (I_CE && lp_ev && !OFF_ON_LONG && st_ff.power && I_FORCE_OFF_N) |=> O_POWER;
    endproperty
    a_long_stay: assert property (p_long_stay) else $error("Long press dropped power");

    property p_long_irq;
        @(posedge I_SYS_CLK) disable iff (I_RST)
        (I_CE && lp_ev) |=> (st_ff.irq_cnt == LONG_IRQ) ##1 O_IRQ_N_OE;
    endproperty
    a_long_irq: assert property (p_long_irq) else $error("Long pulse length wrong");

    property p_no_retrigger;
        @(posedge I_SYS_CLK) disable iff (I_RST)
        (I_CE && st_ff.lp_done && held) |=> (st_ff.irq_cnt <= $past(st_ff.irq_cnt));
    endproperty
    a_no_retrigger: assert property (p_no_retrigger) else $error("Interrupt retriggered");

    property p_clear;
        @(posedge I_SYS_CLK) disable iff (I_RST)
        (I_CE && !I_FORCE_OFF_N && clr_ok && !db_ev) |=> !O_POWER;
    endproperty
    a_clear: assert property (p_clear) else $error("Clear did not turn off");

    property p_blank;
        @(posedge I_SYS_CLK) disable iff (I_RST)
        (I_CE && st_ff.power && st_ff.blank_cnt != '0 && !lp_ev) |=> O_POWER;
    endproperty
    a_blank: assert property (p_blank) else $error("Clear acted during blanking");

    property p_freeze;
        @(posedge I_SYS_CLK) disable iff (I_RST)
        (!I_CE) |=> (st_ff == $past(st_ff));
    endproperty
    a_freeze: assert property (p_freeze) else $error("State moved with enable low");

    property p_pulse_stands;
        @(posedge I_SYS_CLK) disable iff (I_RST)
        (I_CE && st_ff.irq_cnt > 32'h1) |=> O_IRQ_N_OE;
    endproperty
    a_pulse_stands: assert property (p_pulse_stands) else $error("Pulse ended early");

    property p_pulse_ends;
        @(posedge I_SYS_CLK) disable iff (I_RST)
        (I_CE && st_ff.irq_cnt == 32'h1 && !db_ev && !lp_ev) |=> !O_IRQ_N_OE;
    endproperty
    a_pulse_ends: assert property (p_pulse_ends) else $error("Pulse ran too long");

    property p_off_ignore;
        @(posedge I_SYS_CLK) disable iff (I_RST)
        (I_CE && !st_ff.power && !db_ev) |=> !O_POWER;
    endproperty
    a_off_ignore: assert property (p_off_ignore) else $error("Power rose while off");

    property p_blank_load;
        @(posedge I_SYS_CLK) disable iff (I_RST)
        (I_CE && db_ev) |=> (st_ff.blank_cnt == BLANK);
    endproperty
    a_blank_load: assert property (p_blank_load) else $error("Blanking not loaded");

    property p_power_hold;
        @(posedge I_SYS_CLK) disable iff (I_RST)
        (I_CE && st_ff.power && I_FORCE_OFF_N && !(lp_ev && OFF_ON_LONG)) |=> O_POWER;
    endproperty
    a_power_hold: assert property (p_power_hold) else $error("Power dropped");

    property p_off_cause;
        @(posedge I_SYS_CLK) disable iff (I_RST)
        $fell(O_POWER) |-> $past(I_CE) && ($past(lp_ev) || !$past(I_FORCE_OFF_N));
    endproperty
    a_off_cause: assert property (p_off_cause) else $error("Power fell without cause");

    property p_db_once;
        @(posedge I_SYS_CLK) disable iff (I_RST)
        (I_CE && st_ff.db_done && held) |=> st_ff.db_done;
    endproperty
    a_db_once: assert property (p_db_once) else $error("Debounce event rearmed");

    property p_lp_once;
        @(posedge I_SYS_CLK) disable iff (I_RST)
        (I_CE && st_ff.lp_done && held) |=> st_ff.lp_done;
    endproperty
    a_lp_once: assert property (p_lp_once) else $error("Long event rearmed");

    property p_press_sat;
        @(posedge I_SYS_CLK) disable iff (I_RST)
        (st_ff.press_cnt <= LONG_PRESS);
    endproperty
    a_press_sat: assert property (p_press_sat) else $error("Press count overran");

    property p_rearm;
        @(posedge I_SYS_CLK) disable iff (I_RST)
        (I_CE && !held) |=> (!st_ff.db_done && !st_ff.lp_done);
    endproperty
    a_rearm: assert property (p_rearm) else $error("Release did not rearm");
endmodule

// ---- hw/pbo_glitch.sv ----
// Glitch filter that holds a press through short high bounces
`timescale 1ns/1ps
module pbo_glitch
    import pbo_pkg::*;
#(
    parameter logic [31:0] GLITCH = GLITCH_CYC
)
(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_ce,
    input wire logic i_button_in_n,
    output logic o_held
);
    pbo_filt_t st_ff;
    pbo_filt_t nxt_st;

    always_comb
    begin
        nxt_st = st_ff;
        if (!i_button_in_n)
        begin
            nxt_st.held = 1'b1;
            nxt_st.high_cnt = '0;
        end
        else if (st_ff.held)
        begin
            // Release counts only once high for the whole window
            if (st_ff.high_cnt >= GLITCH - 32'h1)
            begin
                nxt_st.held = 1'b0;
                nxt_st.high_cnt = '0;
            end
            else
            begin
                nxt_st.high_cnt = st_ff.high_cnt + 32'h1;
            end
        end
    end

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            st_ff <= '0;
        end
        else if (i_ce)
        begin
            st_ff <= nxt_st;
        end
    end

    assign o_held = st_ff.held;

    property p_glitch_hold;
        @(posedge i_clk) disable iff (i_rst)
        (i_ce && st_ff.held && i_button_in_n && st_ff.high_cnt < GLITCH - 32'h1) |=> st_ff.held;
    endproperty
    a_glitch_hold: assert property (p_glitch_hold) else $error("Release taken before filter");
endmodule

// ---- hw/pbo_pkg.sv ----
// Constants and state types for the pushbutton on/off controller
package pbo_pkg;
    localparam int unsigned CLK_MHZ = 125;
    localparam int unsigned GLITCH_US = 600;
    localparam int unsigned DEBOUNCE_MS = 50;
    localparam int unsigned LONG_PRESS_MS = 8000;
    localparam int unsigned IRQ_MS = 32;
    localparam int unsigned LONG_IRQ_MULT = 4;
    localparam int unsigned BLANK_MULT = 2;
    localparam logic [31:0] GLITCH_CYC = 32'(GLITCH_US * CLK_MHZ);
    localparam logic [31:0] DEBOUNCE_CYC = 32'(DEBOUNCE_MS * 1000 * CLK_MHZ);
    localparam logic [31:0] LONG_PRESS_CYC = 32'(LONG_PRESS_MS * 1000 * CLK_MHZ);
    localparam logic [31:0] IRQ_CYC = 32'(IRQ_MS * 1000 * CLK_MHZ);
    localparam logic OFF_ON_LONG_DEF = 1'b1;

    typedef struct packed {
        logic [31:0] high_cnt;
        logic held;
    } pbo_filt_t;

    typedef struct packed {
        logic [31:0] press_cnt;
        logic db_done;
        logic lp_done;
        logic power;
        logic [31:0] irq_cnt;
        logic [31:0] blank_cnt;
    } pbo_state_t;
endpackage

// ---- verification/pbo_switch.sv ----
// Pushbutton switch model with pull-up and optional contact bounce
`timescale 1ns/1ps
module pbo_switch
(
    input wire logic i_press,
    input wire logic i_bounce,
    output logic o_button_n
);
    // Open contact reads high through the pull-up
    assign o_button_n = ~(i_press & ~i_bounce);
endmodule

// ---- verification/test_pbo_ctrl.sv ----
// Self-checking bench for the pushbutton on/off controller
`timescale 1ns/1ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin mismatches++; \
    $display("[FAIL] t=%0t got=%0h exp=%0h", $time, g, e); end end
module test_pbo_ctrl;
    import pbo_pkg::*;
    localparam logic [31:0] IL = 32'h8;
    localparam logic [31:0] GL = 32'h4;
    localparam logic [31:0] DB = 32'h14;
    localparam logic [31:0] LP = 32'hC8;
    logic clk, rst, press, bounce, clr_n, btn_n, power, irq_out, irq_oe, power2;
    logic ce, irq_oe2;
    int mismatches = 0;
    int samples_checked = 0;
    pbo_switch SW(.i_press(press), .i_bounce(bounce), .o_button_n(btn_n));
    pbo_ctrl #(.GLITCH(GL), .DEBOUNCE(DB), .LONG_PRESS(LP), .IRQ_LEN(IL),
        .OFF_ON_LONG(1'b1)) DUT(.I_SYS_CLK(clk), .I_RST(rst), .I_CE(ce),
        .I_BUTTON_IN_N(btn_n), .I_FORCE_OFF_N(clr_n), .O_POWER(power),
        .O_IRQ_N_OUT(irq_out), .O_IRQ_N_OE(irq_oe));
    // Stay-on variant sharing the same switch
    pbo_ctrl #(.GLITCH(GL), .DEBOUNCE(DB), .LONG_PRESS(LP), .IRQ_LEN(IL),
        .OFF_ON_LONG(1'b0)) DUT_STAY(.I_SYS_CLK(clk), .I_RST(rst), .I_CE(ce),
        .I_BUTTON_IN_N(btn_n), .I_FORCE_OFF_N(clr_n), .O_POWER(power2),
        .O_IRQ_N_OUT(), .O_IRQ_N_OE(irq_oe2));
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic summarize;
        $display("comparisons %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic t_debounce;
        press <= 1'b1;
        cyc(8);
        bounce <= 1'b1;
        cyc(2);
        bounce <= 1'b0;
        cyc(8);
        `CHK(power, 1'b0)
        cyc(6);
        `CHK(power, 1'b1)
        `CHK(irq_oe, 1'b1)
        `CHK(irq_out, 1'b0)
        cyc(8);
        `CHK(irq_oe, 1'b0)
        press <= 1'b0;
        cyc(10);
        `CHK(power, 1'b1)
        $display("debounce test done");
    endtask
    task automatic t_clear;
        clr_n <= 1'b0;
        cyc(3);
        `CHK(power, 1'b0)
        press <= 1'b1;
        cyc(31);
        `CHK(power, 1'b1)
        cyc(10);
        `CHK(power, 1'b0)
        clr_n <= 1'b1;
        press <= 1'b0;
        cyc(10);
        $display("clear test done");
    endtask
    task automatic t_restart;
        press <= 1'b1;
        cyc(15);
        press <= 1'b0;
        cyc(10);
        press <= 1'b1;
        cyc(15);
        `CHK(power, 1'b0)
        press <= 1'b0;
        cyc(10);
        $display("restart test done");
    endtask
    task automatic t_long;
        int n;
        press <= 1'b1;
        n = 0;
        while (power !== 1'b1 && n < 300)
        begin
            cyc(1);
            n++;
        end
        if (n == 300)
        begin
            mismatches++;
            summarize();
        end
        cyc(172);
        `CHK(irq_oe, 1'b0)
        cyc(10);
        `CHK(power, 1'b0)
        `CHK(power2, 1'b1)
        `CHK(irq_oe2, 1'b1)
        `CHK(irq_oe, 1'b1)
        cyc(23);
        `CHK(irq_oe, 1'b1)
        cyc(12);
        `CHK(irq_oe, 1'b0)
        `CHK(irq_oe2, 1'b0)
        cyc(60);
        `CHK(irq_oe, 1'b0)
        press <= 1'b0;
        cyc(10);
        $display("long press test done");
    endtask
    task automatic t_enable;
        press <= 1'b1;
        cyc(23);
        `CHK(power, 1'b1)
        ce <= 1'b0;
        press <= 1'b0;
        cyc(20);
        // Pulse of 8 would have ended had the enable not frozen it
        `CHK(irq_oe, 1'b1)
        `CHK(power2, 1'b1)
        ce <= 1'b1;
        cyc(10);
        `CHK(irq_oe, 1'b0)
        `CHK(power, 1'b1)
        $display("enable test done");
    endtask
    initial
    begin
        rst = 1'b1;
        press = 1'b0;
        bounce = 1'b0;
        clr_n = 1'b1;
        ce = 1'b1;
        cyc(12);
        rst <= 1'b0;
        cyc(2);
        `CHK(power, 1'b0)
        t_debounce();
        t_clear();
        t_restart();
        t_long();
        t_enable();
        summarize();
    end
endmodule
